// >>> design/active_energy_gain_offset_cal.sv
`timescale 1ns/10ps
// How it works
// - One gain LSB scales energy and pulse rate by one part in 4096.
// - Gain setting is signed two's complement, covering up to 50 percent.
// - Gain acts before both the pulse output and the energy accumulators.
// - Energy per pulse is set by numerator and denominator alone.
// - Energy divider sits outside the pulse chain, pulse rate unaffected.
// - Line mode accumulates over the programmed half line cycle count.
// - At window end line energy is latched; the interrupt goes low one clock later.
// - First line result after setup may be short; host discards it.
// - After the first window every following window has exact length.
// - Energy accumulators update once every four clocks.
// - Signed offset is added to active power once every four clocks.
// - Low eight offset bits are a fraction of a gain-corrected active power LSB.
// - One offset LSB equals two to minus 33 of an energy LSB.
// - Line period is counted in units of eight clocks.
module active_energy_gain_offset_cal
  import energy_cal_pkg::*;
#(
  parameter int PULSE_CYC = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Datapath inputs
  input wire logic signed [POWER_W-1:0] power_i,
  input wire logic volt_pos_i,
  // Outputs
  output logic calibration_pulse_out_o,
  output logic irq_n_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a <= OFS_PERIOD);
    return ok;
  endfunction

  // ****************************************************************
  // Settings and state
  // ****************************************************************
  logic line_en_r;
  logic irq_en_r;
  logic done_r;
  logic [GAIN_W-1:0] active_power_gain_r;
  logic [OFFSET_W-1:0] active_power_offset_r;
  logic [RATIO_W-1:0] pulse_ratio_numerator_r;
  logic [RATIO_W-1:0] pulse_ratio_denominator_r;
  logic [DIV_W-1:0] energy_divider_r;
  logic [HALF_LINE_CYCLE_COUNT_W-1:0] half_line_cycle_count_r;
  logic [ENERGY_W-1:0] active_energy_accum_r;
  logic [ENERGY_W-1:0] line_active_energy_r;
  logic [ENERGY_W-1:0] line_sum_r;
  logic [HALF_LINE_CYCLE_COUNT_W-1:0] half_cnt_r;
  logic [FINE_W-1:0] fine_r;
  logic signed [DIV_W:0] div_sub_r;
  logic [1:0] tick_r;
  logic tick;

  // Bus side
  wr_state_t wr_state_r;
  rd_state_t rd_state_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  logic [31:0] rd_mux;
  logic [31:0] wr_old;
  logic [31:0] wr_val;

  // Datapath
  logic signed [GAIN_W+1:0] gain_mul;
  logic signed [POWER_W+GAIN_W+1:0] prod;
  logic signed [FINE_W+2:0] addend;
  logic signed [FINE_W+2:0] fine_sum;
  logic signed [2:0] carry;
  logic signed [DIV_W:0] div_eff;
  logic signed [DIV_W:0] div_next;
  logic signed [1:0] e_step;
  logic quantum;
  logic half_cycle;
  logic [PERIOD_W-1:0] period;
  logic window_end;
  pulse_ratio_t ratio;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = (wr_state_r == WR_RESP);
  assign do_write = aw_hold_r && w_hold_r && (wr_state_r == WR_COLLECT);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && !aw_hold_r)
    begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (do_write)
      aw_hold_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      w_hold_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && !w_hold_r)
    begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (do_write)
      w_hold_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_state_r <= WR_COLLECT;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      case (wr_state_r)
        WR_COLLECT:
        begin
          if (do_write)
          begin
            wr_state_r <= WR_RESP;
            s_axi_bresp <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready)
            wr_state_r <= WR_COLLECT;
        end
        default:
          wr_state_r <= WR_COLLECT;
      endcase
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb
  begin
    case (aw_addr_r)
      OFS_CTRL: wr_old = {30'h0, irq_en_r, line_en_r};
      OFS_GAIN: wr_old = {20'h0, active_power_gain_r};
      OFS_OFFSET: wr_old = {16'h0, active_power_offset_r};
      OFS_NUM: wr_old = {20'h0, pulse_ratio_numerator_r};
      OFS_DEN: wr_old = {20'h0, pulse_ratio_denominator_r};
      OFS_DIV: wr_old = {24'h0, energy_divider_r};
      OFS_HALF_LINE_CYCLE_COUNT: wr_old = {16'h0, half_line_cycle_count_r};
      default: wr_old = 32'h00000000;
    endcase
    wr_val = merge(wr_old, w_data_r, w_strb_r);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      line_en_r <= 1'b0;
      irq_en_r <= 1'b0;
      active_power_gain_r <= '0;
      active_power_offset_r <= '0;
      pulse_ratio_numerator_r <= RATIO_RST;
      pulse_ratio_denominator_r <= RATIO_RST;
      energy_divider_r <= DIV_RST;
      half_line_cycle_count_r <= HALF_LINE_CYCLE_COUNT_RST;
    end
    else if (do_write)
    begin
      case (aw_addr_r)
        OFS_CTRL:
        begin
          line_en_r <= wr_val[CTRL_LINE_BIT];
          irq_en_r <= wr_val[CTRL_IRQ_BIT];
        end
        OFS_GAIN: active_power_gain_r <= wr_val[GAIN_W-1:0];
        OFS_OFFSET: active_power_offset_r <= wr_val[OFFSET_W-1:0];
        OFS_NUM: pulse_ratio_numerator_r <= wr_val[RATIO_W-1:0];
        OFS_DEN: pulse_ratio_denominator_r <= wr_val[RATIO_W-1:0];
        OFS_DIV: energy_divider_r <= wr_val[DIV_W-1:0];
        OFS_HALF_LINE_CYCLE_COUNT: half_line_cycle_count_r <= wr_val[HALF_LINE_CYCLE_COUNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = (rd_state_r == RD_IDLE);
  assign s_axi_rvalid = (rd_state_r == RD_VALID);

  always_comb
  begin
    case (s_axi_araddr)
      OFS_CTRL: rd_mux = {30'h0, irq_en_r, line_en_r};
      OFS_STATUS: rd_mux = {31'h0, done_r};
      OFS_GAIN: rd_mux = {20'h0, active_power_gain_r};
      OFS_OFFSET: rd_mux = {16'h0, active_power_offset_r};
      OFS_NUM: rd_mux = {20'h0, pulse_ratio_numerator_r};
      OFS_DEN: rd_mux = {20'h0, pulse_ratio_denominator_r};
      OFS_DIV: rd_mux = {24'h0, energy_divider_r};
      OFS_HALF_LINE_CYCLE_COUNT: rd_mux = {16'h0, half_line_cycle_count_r};
      OFS_ACTIVE_ENERGY_ACCUM: rd_mux = {8'h0, active_energy_accum_r};
      OFS_LINE_ACTIVE_ENERGY: rd_mux = {8'h0, line_active_energy_r};
      OFS_PERIOD: rd_mux = {16'h0, period};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_state_r <= RD_IDLE;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      case (rd_state_r)
        RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rd_state_r <= RD_VALID;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_VALID:
        begin
          if (s_axi_rready)
            rd_state_r <= RD_IDLE;
        end
        default:
          rd_state_r <= RD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Gain and offset correction
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      tick_r <= 2'h0;
    else
      tick_r <= tick_r + 2'h1;
  end

  assign tick = (tick_r == TICK_LAST);

  always_comb
  begin
    gain_mul = GAIN_UNITY + {{2{active_power_gain_r[GAIN_W-1]}},
                             active_power_gain_r};
    prod = power_i * gain_mul;
    addend = {{2{prod[POWER_W+GAIN_W+1]}},
              prod[POWER_W+GAIN_W+1:GAIN_FRAC],
              {OFFSET_FRAC{1'b0}}}
           + {{(FINE_W+3-OFFSET_W){active_power_offset_r[OFFSET_W-1]}},
              active_power_offset_r};
    fine_sum = $signed({3'h0, fine_r}) + addend;
    carry = fine_sum[FINE_W+2:FINE_W];
  end

  // Fraction below one energy LSB carries 33 bits
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      fine_r <= '0;
    else if (tick)
      fine_r <= fine_sum[FINE_W-1:0];
  end

  // Pulse chain sees every quantum before the divider
  assign quantum = tick && (carry != 3'sh0);
  assign ratio = '{num: pulse_ratio_numerator_r,
                   den: pulse_ratio_denominator_r};

  cal_pulse_gen #(
    .PULSE_CYC(PULSE_CYC)
  ) u_pulse (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .quantum_i(quantum),
    .ratio_i(ratio),
    .calibration_pulse_out_o(calibration_pulse_out_o)
  );

  // ****************************************************************
  // Energy divider and accumulation
  // ****************************************************************
  always_comb
  begin
    div_eff = (energy_divider_r == '0) ? 9'sh001
                                       : $signed({1'b0, energy_divider_r});
    div_next = div_sub_r + {{(DIV_W-2){carry[2]}}, carry};
    e_step = 2'sh0;
    if (tick && (div_next >= div_eff))
      e_step = 2'sh1;
    else if (tick && (div_next <= -div_eff))
      e_step = -2'sh1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      div_sub_r <= '0;
    else if (tick)
      div_sub_r <= (e_step != 2'sh0) ? 9'sh000 : div_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      active_energy_accum_r <= '0;
    else
      active_energy_accum_r <= active_energy_accum_r
                             + {{(ENERGY_W-2){e_step[1]}}, e_step};
  end

  // ****************************************************************
  // Line cycle accumulation
  // ****************************************************************
  line_period_meter u_period (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .volt_pos_i(volt_pos_i),
    .half_cycle_o(half_cycle),
    .period_o(period)
  );

  // Window opens when the mode is enabled, so the first one may be short
  assign window_end = line_en_r && half_cycle
                   && (half_cnt_r + 16'h0001 >= half_line_cycle_count_r);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !line_en_r)
    begin
      half_cnt_r <= '0;
      line_sum_r <= '0;
    end
    else if (window_end)
    begin
      half_cnt_r <= '0;
      line_sum_r <= {{(ENERGY_W-2){e_step[1]}}, e_step};
    end
    else
    begin
      if (half_cycle)
        half_cnt_r <= half_cnt_r + 16'h0001;
      line_sum_r <= line_sum_r + {{(ENERGY_W-2){e_step[1]}}, e_step};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      line_active_energy_r <= '0;
    else if (window_end)
      line_active_energy_r <= line_sum_r;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      done_r <= 1'b0;
    else if (window_end)
      done_r <= 1'b1;
    else if (do_write && aw_addr_r == OFS_STATUS
             && w_strb_r[0] && w_data_r[STAT_DONE_BIT])
      done_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      irq_n_o <= 1'b1;
    else
      irq_n_o <= !(done_r && irq_en_r);
  end

endmodule

// >>> design/cal_pulse_gen.sv
`timescale 1ns/10ps
// Turns energy quanta into calibration pulses by a num+1 / den+1 ratio
module cal_pulse_gen
  import energy_cal_pkg::*;
#(
  parameter int PULSE_CYC = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Energy quantum and ratio
  input wire logic quantum_i,
  input wire pulse_ratio_t ratio_i,
  // Pulse output
  output logic calibration_pulse_out_o
);

  logic [RATIO_W+1:0] frac_r;
  logic [RATIO_W+1:0] frac_sum;
  logic [RATIO_W+1:0] den_eff;
  logic fire;
  logic [7:0] width_r;

  always_comb
  begin
    den_eff = {2'h0, ratio_i.den} + 14'h0001;
    frac_sum = frac_r + (quantum_i ? {2'h0, ratio_i.num} + 14'h0001
                                   : 14'h0000);
    fire = (frac_sum >= den_eff);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      frac_r <= '0;
    else if (fire)
      frac_r <= frac_sum - den_eff;
    else
      frac_r <= frac_sum;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      width_r <= 8'h00;
    else if (fire)
      width_r <= 8'(PULSE_CYC);
    else if (width_r != 8'h00)
      width_r <= width_r - 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      calibration_pulse_out_o <= 1'b0;
    else
      calibration_pulse_out_o <= fire || (width_r > 8'h01);
  end

endmodule

// >>> design/line_period_meter.sv
`timescale 1ns/10ps
// Detects voltage zero crossings and measures the line period
module line_period_meter
  import energy_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Voltage polarity from the datapath
  input wire logic volt_pos_i,
  // Results
  output logic half_cycle_o,
  output logic [PERIOD_W-1:0] period_o
);

  logic pol_r;
  logic [2:0] pre_r;
  logic [PERIOD_W-1:0] cnt_r;
  logic rise;

  assign rise = volt_pos_i && !pol_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pol_r <= 1'b0;
      half_cycle_o <= 1'b0;
    end
    else
    begin
      pol_r <= volt_pos_i;
      half_cycle_o <= volt_pos_i ^ pol_r;
    end
  end

  // Period counts in units of eight clocks
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pre_r <= 3'h0;
      cnt_r <= '0;
      period_o <= '0;
    end
    else if (rise)
    begin
      // The crossing clock itself is the first of the next eight
      pre_r <= 3'h1;
      cnt_r <= '0;
      period_o <= cnt_r;
    end
    else
    begin
      pre_r <= pre_r + 3'h1;
      if (pre_r == PERIOD_PRESCALE_LAST && cnt_r != '1)
        cnt_r <= cnt_r + 16'h0001;
    end
  end

endmodule

// >>> inc/energy_cal_pkg.sv
package energy_cal_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_GAIN = 6'h08;
  localparam logic [5:0] OFS_OFFSET = 6'h0C;
  localparam logic [5:0] OFS_NUM = 6'h10;
  localparam logic [5:0] OFS_DEN = 6'h14;
  localparam logic [5:0] OFS_DIV = 6'h18;
  localparam logic [5:0] OFS_HALF_LINE_CYCLE_COUNT = 6'h1C;
  localparam logic [5:0] OFS_ACTIVE_ENERGY_ACCUM = 6'h20;
  localparam logic [5:0] OFS_LINE_ACTIVE_ENERGY = 6'h24;
  localparam logic [5:0] OFS_PERIOD = 6'h28;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int CTRL_LINE_BIT = 0;
  localparam int CTRL_IRQ_BIT = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int POWER_W = 24;
  localparam int GAIN_W = 12;
  localparam int OFFSET_W = 16;
  localparam int RATIO_W = 12;
  localparam int DIV_W = 8;
  localparam int HALF_LINE_CYCLE_COUNT_W = 16;
  localparam int ENERGY_W = 24;
  localparam int PERIOD_W = 16;
  localparam int GAIN_FRAC = 12;
  localparam int OFFSET_FRAC = 8;
  localparam int FINE_W = 33;

  // ****************************************************************
  // Reset values and arithmetic constants
  // ****************************************************************
  localparam logic [11:0] RATIO_RST = 12'h03F;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [15:0] HALF_LINE_CYCLE_COUNT_RST = 16'hFFFF;
  localparam logic signed [13:0] GAIN_UNITY = 14'sh1000;
  localparam logic [1:0] TICK_LAST = 2'h3;
  localparam logic [2:0] PERIOD_PRESCALE_LAST = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [RATIO_W-1:0] num;
    logic [RATIO_W-1:0] den;
  } pulse_ratio_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h0,
    WR_RESP = 2'h1
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_VALID = 2'h1
  } rd_state_t;

endpackage

// >>> verif/energy_cal_monitor.sv
`timescale 1ns/10ps
module energy_cal_monitor
  import energy_cal_pkg::*;
#(
  parameter int PULSE_CYC = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Outputs
  input wire logic calibration_pulse_out_o,
  input wire logic irq_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_irq_hold;
    !irq_n_o && !s_axi_awvalid && !$past(s_axi_awvalid) && !s_axi_bvalid
      |=> !irq_n_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt released without a write");
  property p_pulse_w;
    $rose(calibration_pulse_out_o) |-> calibration_pulse_out_o[*3]
      ##[1:3] !calibration_pulse_out_o;
  endproperty
  a_pulse_w: assert property (p_pulse_w)
    else $error("pulse width wrong");
  property p_aw_busy;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_busy: assert property (p_aw_busy)
    else $error("address taken twice");
  property p_w_busy;
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy)
    else $error("data taken twice");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  property p_rd_err;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > OFS_PERIOD
      || s_axi_araddr[1:0] != 2'h0) |-> ##[1:2] (s_axi_rvalid
      && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0);
  endproperty
  a_rd_err: assert property (p_rd_err)
    else $error("bad read address not refused");
  c_irq: cover property ($fell(irq_n_o));
  c_pulse: cover property ($rose(calibration_pulse_out_o));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind active_energy_gain_offset_cal energy_cal_monitor #(
  .PULSE_CYC(PULSE_CYC)
) u_mon (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .calibration_pulse_out_o(calibration_pulse_out_o),
  .irq_n_o(irq_n_o)
);

// >>> verif/line_source.sv
`timescale 1ns/10ps
// Front end stand-in: steady power and a square line polarity
module line_source
  import energy_cal_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Settings
  input wire logic [15:0] half_len_i,
  input wire logic signed [POWER_W-1:0] level_i,
  // Datapath side
  output logic signed [POWER_W-1:0] power_o,
  output logic volt_pos_o
);
  logic [15:0] cnt_r;

  // Polarity flips every half_len_i clocks; zero keeps it still
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || half_len_i == 16'h0)
    begin
      cnt_r <= 16'h0;
      volt_pos_o <= 1'b0;
    end
    else if (cnt_r == half_len_i - 16'h1)
    begin
      cnt_r <= 16'h0;
      volt_pos_o <= ~volt_pos_o;
    end
    else
      cnt_r <= cnt_r + 16'h1;
  end
  assign power_o = level_i;
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
  import energy_cal_pkg::*;
  logic clk_i, rst_n_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, volt_pos, pulse, irq_n;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic signed [POWER_W-1:0] power, level;
  logic [15:0] half_len;
  int fails, tests_run, pulses, cyc, t0, p0;
  logic [31:0] rst_tab [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3F,
    32'h3F, 32'h0, 32'hFFFF, 32'h0, 32'h0};
  logic [11:0] gain_tab [4] = '{12'h000, 12'h800, 12'h7FF, 12'h000};
  logic [7:0] div_tab [4] = '{8'h00, 8'h00, 8'h00, 8'h02};
  int e_lo [4] = '{32, 16, 47, 16};
  int e_hi [4] = '{32, 16, 48, 16};
  int p_lo [4] = '{8, 4, 11, 8};
  int p_hi [4] = '{8, 4, 12, 8};

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  always @(posedge pulse) pulses <= pulses + 1;

  active_energy_gain_offset_cal #(.PULSE_CYC(4)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_i(power), .volt_pos_i(volt_pos),
    .calibration_pulse_out_o(pulse), .irq_n_o(irq_n));
  line_source u_src (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .half_len_i(half_len), .level_i(level), .power_o(power),
    .volt_pos_o(volt_pos));

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic in_range(input logic [31:0] got, input int lo, hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      fails++;
      $display("ERROR t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1)
    begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [5:0] a, input logic [31:0] d);
    wr(a, d, 4'hF);
    check(32'(rsp), 32'(RESP_OKAY));
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1)
    begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e,
                        input logic [1:0] r);
    rd_reg(a);
    check(rd, e);
    check(32'(rsp), 32'(r));
  endtask
  task automatic wait_irq;
    @(posedge clk_i);
    while (irq_n !== 1'b0) @(posedge clk_i);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_i);
    fails++;
    give_verdict();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    rst_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    level = 24'h000000;
    half_len = 16'h0000;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd_chk(6'(i * 4), rst_tab[i], RESP_OKAY);
    wr_ok(OFS_GAIN, 32'hFFFFFFFF);
    rd_chk(OFS_GAIN, 32'h00000FFF, RESP_OKAY);
    wr(OFS_GAIN, 32'h0, 4'h1);
    rd_chk(OFS_GAIN, 32'h00000F00, RESP_OKAY);
    wr_ok(OFS_OFFSET, 32'hFFFF8000);
    rd_chk(OFS_OFFSET, 32'h00008000, RESP_OKAY);
    wr(6'h30, 32'h1, 4'hF);
    check(32'(rsp), 32'(RESP_SLVERR));
    rd_chk(6'h2C, 32'h0, RESP_SLVERR);
    rd_chk(6'h02, 32'h0, RESP_SLVERR);
    level <= 24'h400000;
    half_len <= 16'h0100;
    wr_ok(OFS_GAIN, 32'h0);
    wr_ok(OFS_OFFSET, 32'h0);
    wr_ok(OFS_DEN, 32'h3);
    wr_ok(OFS_NUM, 32'h0);
    wr_ok(OFS_CTRL, 32'h3);
    wr_ok(OFS_HALF_LINE_CYCLE_COUNT, 32'h4);
    wr_ok(OFS_STATUS, 32'h1);
    wait_irq();
    repeat (20) @(posedge clk_i);
    check(32'(irq_n), 32'h0);
    rd_chk(OFS_PERIOD, 32'h40, RESP_OKAY);
    wr_ok(OFS_STATUS, 32'h1);
    repeat (3) @(posedge clk_i);
    check(32'(irq_n), 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr_ok(OFS_GAIN, 32'(gain_tab[i]));
      wr_ok(OFS_DIV, 32'(div_tab[i]));
      wr_ok(OFS_STATUS, 32'h1);
      wait_irq();
      t0 = cyc;
      p0 = pulses;
      wr_ok(OFS_STATUS, 32'h1);
      wait_irq();
      check(32'(cyc - t0), 32'h400);
      in_range(32'(pulses - p0), p_lo[i], p_hi[i]);
      rd_reg(OFS_LINE_ACTIVE_ENERGY);
      check(32'(rsp), 32'(RESP_OKAY));
      in_range(rd, e_lo[i], e_hi[i]);
    end
    give_verdict();
  end
endmodule
